// ==== design/tcs_pkg.sv ====
/*
  Constants for the timer channel status and interrupt mask block:
  register offsets, status bit positions, widths and reset values.
  Assumes a byte-addressed register port with one 32-bit word per
  register and the read data returned one cycle after the strobe.
*/
// Summary of operation
// - Overflow sets status bit 0; it holds until software reads status.
// - Capture mode: double load without read sets bit 1; zero otherwise.
// - Generation mode: compare A match sets bit 2; zero in capture mode.
// - Generation mode: compare B match sets bit 3; zero in capture mode.
// - Either mode: compare C match sets bit 4; cleared by status read.
// - Capture mode: capture A load sets bit 5; zero in generation mode.
// - Capture mode: capture B load sets bit 6; zero in generation mode.
// - Either mode: external trigger sets bit 7; cleared by status read.
// - Bit 16 shows the live counter clock enable, unlatched.
// - Bit 17 mirrors line A: pin in capture, driven level in generation.
// - Bit 18 mirrors line B: pin in capture, driven level in generation.
// - Ones written to enable word bits 0..7 set mask bits.
// - Ones written to disable word bits 0..7 clear mask bits.
// - Mask view word reports the eight enabled interrupts in bits 0..7.
// - Mode bit zero selects capture, one selects generation.

package tcs_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int         ADDR_W          = 8;
  localparam int         DATA_W          = 32;
  localparam logic [7:0] OFS_STATUS      = 8'h00;
  localparam logic [7:0] OFS_IRQ_SET     = 8'h04;
  localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h08;
  localparam logic [7:0] OFS_MASK_VIEW   = 8'h0C;

  // ------------------------------------------------------------------
  // Status word layout
  // ------------------------------------------------------------------
  localparam int         NUM_EVENTS      = 8;
  localparam int         BIT_OVERFLOW    = 0;
  localparam int         BIT_OVERRUN     = 1;
  localparam int         BIT_MATCH_A     = 2;
  localparam int         BIT_MATCH_B     = 3;
  localparam int         BIT_MATCH_C     = 4;
  localparam int         BIT_CAP_A       = 5;
  localparam int         BIT_CAP_B       = 6;
  localparam int         BIT_EXT_TRIG    = 7;
  localparam int         BIT_CLOCK_ON    = 16;
  localparam int         BIT_LINE_A      = 17;
  localparam int         BIT_LINE_B      = 18;

  // Flags that only live in one mode
  localparam logic [7:0] CAPTURE_ONLY    = 8'h62;
  localparam logic [7:0] GENERATE_ONLY   = 8'h0C;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] FLAGS_RESET     = 8'h00;
  localparam logic [7:0] MASK_RESET      = 8'h00;
  localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;

endpackage

// ==== design/tcs_sticky_flags.sv ====
/*
  Bank of sticky event flags. A set pulse wins over a clear pulse in
  the same cycle, so no event is lost to a concurrent clear.
  Assumes synchronous active-high reset on the block clock.
*/
`timescale 1ns/1ns

module tcs_sticky_flags #(
  parameter int              WIDTH     = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Control
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clear_i,
  // State
  output logic      [WIDTH-1:0] flags_r
);

  // Refuse widths the flag bank cannot hold
  if (WIDTH < 1)
  begin
    $error("tcs_sticky_flags: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] flags_nxt;

  assign flags_nxt = set_i | (flags_r & ~clear_i);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      flags_r <= RESET_VAL;
    else
      flags_r <= flags_nxt;
  end

endmodule

// ==== design/tcs_mask_reg.sv ====
/*
  Interrupt mask held as a set/clear register pair. Ones set or clear,
  zeros leave bits alone. A bit written to both sets and clears in one
  cycle ends up set. Assumes synchronous active-high reset.
*/
`timescale 1ns/1ns

module tcs_mask_reg #(
  parameter int              WIDTH     = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Write strobes with their data
  input  wire logic             set_we,
  input  wire logic             clr_we,
  input  wire logic [WIDTH-1:0] wdata,
  // State
  output logic      [WIDTH-1:0] mask_r
);

  // Refuse widths the mask cannot hold
  if (WIDTH < 1)
  begin
    $error("tcs_mask_reg: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] mask_nxt;

  always_comb
  begin
    mask_nxt = mask_r;
    if (clr_we)
      mask_nxt = mask_nxt & ~wdata;
    if (set_we)
      mask_nxt = mask_nxt | wdata;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      mask_r <= RESET_VAL;
    else
      mask_r <= mask_nxt;
  end

endmodule

// ==== design/tcs_status_irq.sv ====
/*
  Status and interrupt part of one timer channel: sticky event flags
  cleared by a status read, live clock and line mirrors, and a
  set/clear interrupt mask with a read-back view.
  Assumes event strobes are one-cycle pulses synchronous to sys_clk,
  and a register master that never issues read and write together.
*/
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns

module tcs_status_irq (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Channel mode: 0 capture, 1 generation
  input  wire logic        gen_mode,
  // Event strobes from counter, compare and capture logic
  input  wire logic        ev_overflow,
  input  wire logic        ev_match_a,
  input  wire logic        ev_match_b,
  input  wire logic        ev_match_c,
  input  wire logic        ev_capture_a_load,
  input  wire logic        ev_capture_b_load,
  input  wire logic        ev_ext_trigger,
  // Software reads of the capture words
  input  wire logic        capture_a_read,
  input  wire logic        capture_b_read,
  // Live channel state
  input  wire logic        counter_clock_on,
  input  wire logic        io_line_a_pin,
  input  wire logic        io_line_a_drive,
  input  wire logic        io_line_b_pin,
  input  wire logic        io_line_b_drive,
  // Interrupt
  output logic             irq_out
);

  // ------------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------------
  logic status_rd;
  logic mask_rd;
  logic irq_set_wr;
  logic irq_clr_wr;

  assign status_rd  = reg_rd && (reg_addr == tcs_pkg::OFS_STATUS);
  assign mask_rd    = reg_rd && (reg_addr == tcs_pkg::OFS_MASK_VIEW);
  assign irq_set_wr = reg_wr && (reg_addr == tcs_pkg::OFS_IRQ_SET);
  assign irq_clr_wr = reg_wr && (reg_addr == tcs_pkg::OFS_IRQ_CLEAR);

  // ------------------------------------------------------------------
  // Capture overrun tracking
  // ------------------------------------------------------------------
  // A load while the previous value is still unread is an overrun.
  // A read in the same cycle as a load consumes the old value, so the
  // new value stays pending and no overrun is counted.
  logic unread_a_r;
  logic unread_b_r;
  logic overrun_a;
  logic overrun_b;

  assign overrun_a = ev_capture_a_load && unread_a_r && !capture_a_read;
  assign overrun_b = ev_capture_b_load && unread_b_r && !capture_b_read;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      unread_a_r <= 1'b0;
    else if (ev_capture_a_load)
      unread_a_r <= 1'b1;
    else if (capture_a_read)
      unread_a_r <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      unread_b_r <= 1'b0;
    else if (ev_capture_b_load)
      unread_b_r <= 1'b1;
    else if (capture_b_read)
      unread_b_r <= 1'b0;
  end

  // ------------------------------------------------------------------
  // Event flags
  // ------------------------------------------------------------------
  logic [7:0] flag_set;
  logic [7:0] flag_clear;
  logic [7:0] flags_r;
  logic [7:0] mode_keep;
  logic [7:0] flags_view;

  always_comb
  begin
    flag_set = '0;
    flag_set[tcs_pkg::BIT_OVERFLOW] = ev_overflow;
    flag_set[tcs_pkg::BIT_OVERRUN]  = !gen_mode
                                      && (overrun_a || overrun_b);
    flag_set[tcs_pkg::BIT_MATCH_A]  = gen_mode && ev_match_a;
    flag_set[tcs_pkg::BIT_MATCH_B]  = gen_mode && ev_match_b;
    flag_set[tcs_pkg::BIT_MATCH_C]  = ev_match_c;
    flag_set[tcs_pkg::BIT_CAP_A]    = !gen_mode
                                      && ev_capture_a_load;
    flag_set[tcs_pkg::BIT_CAP_B]    = !gen_mode
                                      && ev_capture_b_load;
    flag_set[tcs_pkg::BIT_EXT_TRIG] = ev_ext_trigger;
  end

  // Every flag clears on a status read; a same-cycle set survives
  assign flag_clear = {8{status_rd}};

  tcs_sticky_flags #(
    .WIDTH     (tcs_pkg::NUM_EVENTS),
    .RESET_VAL (tcs_pkg::FLAGS_RESET)
  ) u_flags (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .set_i   (flag_set),
    .clear_i (flag_clear),
    .flags_r (flags_r)
  );

  // Flags of the other mode read zero, even if left over from a switch
  assign mode_keep  = gen_mode ? ~tcs_pkg::CAPTURE_ONLY
                               : ~tcs_pkg::GENERATE_ONLY;
  assign flags_view = flags_r & mode_keep;

  // ------------------------------------------------------------------
  // Interrupt mask
  // ------------------------------------------------------------------
  logic [7:0] mask_r;

  tcs_mask_reg #(
    .WIDTH     (tcs_pkg::NUM_EVENTS),
    .RESET_VAL (tcs_pkg::MASK_RESET)
  ) u_mask (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .set_we  (irq_set_wr),
    .clr_we  (irq_clr_wr),
    .wdata   (reg_wdata[7:0]),
    .mask_r  (mask_r)
  );

  // Level output; combinational so it drops with the clearing read
  assign irq_out = |(flags_view & mask_r);

  // ------------------------------------------------------------------
  // Status word and read data
  // ------------------------------------------------------------------
  logic        line_a_level_mirror;
  logic        line_b_level_mirror;
  logic [31:0] status_word;
  logic [31:0] rdata_nxt;

  assign line_a_level_mirror = gen_mode ? io_line_a_drive
                                        : io_line_a_pin;
  assign line_b_level_mirror = gen_mode ? io_line_b_drive
                                        : io_line_b_pin;

  always_comb
  begin
    status_word = '0;
    status_word[7:0] = flags_view;
    status_word[tcs_pkg::BIT_CLOCK_ON] = counter_clock_on;
    status_word[tcs_pkg::BIT_LINE_A]   = line_a_level_mirror;
    status_word[tcs_pkg::BIT_LINE_B]   = line_b_level_mirror;
  end

  // Write-only words and unmapped offsets read as zero
  always_comb
  begin
    rdata_nxt = '0;
    if (status_rd)
      rdata_nxt = status_word;
    else if (mask_rd)
      rdata_nxt = {24'h00_0000, mask_r};
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      reg_rdata <= tcs_pkg::RDATA_RESET;
    else
      reg_rdata <= rdata_nxt;
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (sys_rst);

  sequence status_read_s;
    reg_rd && (reg_addr == tcs_pkg::OFS_STATUS);
  endsequence

  sequence mask_read_s;
    reg_rd && (reg_addr == tcs_pkg::OFS_MASK_VIEW);
  endsequence

  // Overflow flag is seen by the next status read, then is gone
  ovf_sticky_a: assert property (
    ev_overflow ##1 (status_read_s and !ev_overflow)
    |=> reg_rdata[tcs_pkg::BIT_OVERFLOW]
        && !flags_r[tcs_pkg::BIT_OVERFLOW])
    else $error("overflow flag not held until status read");

  ovf_hold_a: assert property (
    flags_r[tcs_pkg::BIT_OVERFLOW] && !status_rd
    |=> flags_r[tcs_pkg::BIT_OVERFLOW])
    else $error("overflow flag dropped without a status read");

  overrun_set_a: assert property (
    !gen_mode ##1 (!gen_mode && ev_capture_a_load && unread_a_r
                   && !capture_a_read)
    |=> flags_view[tcs_pkg::BIT_OVERRUN])
    else $error("double capture load did not flag overrun");

  overrun_mode_a: assert property (
    gen_mode |-> !status_word[tcs_pkg::BIT_OVERRUN])
    else $error("overrun flag visible in generation mode");

  match_ab_mode_a: assert property (
    !gen_mode |-> status_word[3:2] == 2'b00)
    else $error("compare A or B flag visible in capture mode");

  match_b_set_a: assert property (
    gen_mode && ev_match_b ##1 gen_mode
    |-> flags_view[tcs_pkg::BIT_MATCH_B])
    else $error("compare B match not recorded");

  match_c_cycle_a: assert property (
    ev_match_c ##1 (status_read_s and !ev_match_c)
    ##1 !ev_match_c
    |-> reg_rdata[tcs_pkg::BIT_MATCH_C]
        && !flags_r[tcs_pkg::BIT_MATCH_C])
    else $error("compare C flag not reported then cleared");

  load_mode_a: assert property (
    gen_mode |-> status_word[6:5] == 2'b00)
    else $error("capture load flags visible in generation mode");

  trig_set_wins_a: assert property (
    status_read_s and ev_ext_trigger
    |=> flags_r[tcs_pkg::BIT_EXT_TRIG])
    else $error("trigger lost to a concurrent status read");

  clk_live_a: assert property (
    status_read_s |=> reg_rdata[tcs_pkg::BIT_CLOCK_ON]
                      == $past(counter_clock_on))
    else $error("clock status not live");

  mirror_lines_a: assert property (
    status_read_s |=> reg_rdata[18:17] ==
      ($past(gen_mode)
        ? {$past(io_line_b_drive), $past(io_line_a_drive)}
        : {$past(io_line_b_pin), $past(io_line_a_pin)}))
    else $error("line mirror shows the wrong source");

  mask_set_a: assert property (
    irq_set_wr |=> (mask_r & $past(reg_wdata[7:0]))
                   == $past(reg_wdata[7:0]))
    else $error("enable word did not set mask bits");

  mask_clear_a: assert property (
    irq_clr_wr ##1 !irq_set_wr
    |-> (mask_r & $past(reg_wdata[7:0])) == 8'h00
        && (mask_r | $past(reg_wdata[7:0]))
           == ($past(mask_r) | $past(reg_wdata[7:0])))
    else $error("disable word did not clear only its bits");

  mask_view_a: assert property (
    mask_read_s |=> reg_rdata == {24'h00_0000, $past(mask_r)})
    else $error("mask view does not match mask");

  irq_level_a: assert property (
    irq_out == |(status_word[7:0] & mask_r))
    else $error("interrupt does not follow flags and mask");

  irq_drop_a: assert property (
    status_read_s and (flag_set == 8'h00) |=> !irq_out)
    else $error("interrupt still high after clearing read");

  // ------------------------------------------------------------------
  // Assertions on setting, clearing and read-back
  // ------------------------------------------------------------------
  sequence gen_match_a_s;
    gen_mode && ev_match_a ##1 gen_mode;
  endsequence

  sequence cap_load_a_s;
    !gen_mode && ev_capture_a_load ##1 !gen_mode;
  endsequence

  sequence cap_load_b_s;
    !gen_mode && ev_capture_b_load ##1 !gen_mode;
  endsequence

  match_a_set_a: assert property (
    gen_match_a_s |-> flags_view[tcs_pkg::BIT_MATCH_A])
    else $error("compare A match not recorded");

  match_c_set_a: assert property (
    ev_match_c |=> flags_r[tcs_pkg::BIT_MATCH_C])
    else $error("compare C match not recorded");

  load_a_set_a: assert property (
    cap_load_a_s |-> flags_view[tcs_pkg::BIT_CAP_A])
    else $error("capture A load not recorded");

  load_b_set_a: assert property (
    cap_load_b_s |-> flags_view[tcs_pkg::BIT_CAP_B])
    else $error("capture B load not recorded");

  trig_set_a: assert property (
    ev_ext_trigger |=> flags_r[tcs_pkg::BIT_EXT_TRIG])
    else $error("external trigger not recorded");

  // A read beside the load takes the old value: no overrun
  overrun_none_a: assert property (
    !gen_mode && ev_capture_a_load && capture_a_read
    && !ev_capture_b_load && !flags_r[tcs_pkg::BIT_OVERRUN]
    |=> !flags_r[tcs_pkg::BIT_OVERRUN])
    else $error("overrun flagged for a load read in time");

  unread_track_a: assert property (
    ev_capture_b_load |=> unread_b_r)
    else $error("capture B load not tracked as unread");

  status_clear_a: assert property (
    status_read_s |=> flags_r == $past(flag_set))
    else $error("status read did not clear flags to new events");

  wo_read_zero_a: assert property (
    reg_rd && (reg_addr == tcs_pkg::OFS_IRQ_SET
               || reg_addr == tcs_pkg::OFS_IRQ_CLEAR)
    |=> reg_rdata == tcs_pkg::RDATA_RESET)
    else $error("write-only word did not read as zero");

endmodule

// ==== sim/tb.sv ====
/*
  Self-checking bench for tcs_status_irq: register access, sticky
  flags, mode gating, overrun, mask set/clear and interrupt output.
  Assumes the package offsets and read data one cycle after reg_rd.
*/
`timescale 1ns/1ns

`define CHK(nm, ex, gt) \
  begin \
    check_count++; \
    if ((gt) !== (ex)) \
    begin \
      errors++; \
      $display("ERROR %s expected %h seen %h", nm, ex, gt); \
    end \
  end

module tb;
  // ------------------------------------------------------------------
  // Design signals
  // ------------------------------------------------------------------
  logic        sys_clk   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  logic        gen_mode  = 1'b0;
  // Bit 1 is not a strobe: overrun comes from the loads
  logic [7:0]  ev_r      = 8'h00;
  logic [1:0]  crd_r     = 2'b00;
  // {b_drive, b_pin, a_drive, a_pin, clock_on}
  logic [4:0]  live_r    = 5'h00;
  logic        irq_out;

  // ------------------------------------------------------------------
  // Bench state
  // ------------------------------------------------------------------
  int          errors      = 0;
  int          check_count = 0;
  int          seed        = 36828;
  int          cycles      = 0;
  logic [7:0]  m_flags     = 8'h00;
  logic [7:0]  m_mask      = 8'h00;
  logic        m_unrd_a    = 1'b0;
  logic        m_unrd_b    = 1'b0;
  logic        rd_pend     = 1'b0;
  logic [31:0] exp_q[$];
  string       nm_q[$];
  logic [31:0] m_exp;
  string       m_nm;

  tcs_status_irq tcs_status_irq_i (
    .sys_clk           (sys_clk),
    .sys_rst           (sys_rst),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .gen_mode          (gen_mode),
    .ev_overflow       (ev_r[0]),
    .ev_match_a        (ev_r[2]),
    .ev_match_b        (ev_r[3]),
    .ev_match_c        (ev_r[4]),
    .ev_capture_a_load (ev_r[5]),
    .ev_capture_b_load (ev_r[6]),
    .ev_ext_trigger    (ev_r[7]),
    .capture_a_read    (crd_r[0]),
    .capture_b_read    (crd_r[1]),
    .counter_clock_on  (live_r[0]),
    .io_line_a_pin     (live_r[1]),
    .io_line_a_drive   (live_r[2]),
    .io_line_b_pin     (live_r[3]),
    .io_line_b_drive   (live_r[4]),
    .irq_out           (irq_out)
  );

  always #5 sys_clk = ~sys_clk;

  // ------------------------------------------------------------------
  // Closing report and hang guard
  // ------------------------------------------------------------------
  task automatic end_of_test();
    if (exp_q.size() != 0)
      errors++;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("ERROR cycle_limit expected %0d seen %0d", 19999, cycles);
      end_of_test();
    end
  end

  // ------------------------------------------------------------------
  // Read monitor: one note per read, data one cycle after the strobe
  // ------------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    rd_pend <= reg_rd & ~sys_rst;
    if (rd_pend && exp_q.size() != 0)
    begin
      m_exp = exp_q.pop_front();
      m_nm = nm_q.pop_front();
      `CHK(m_nm, m_exp, reg_rdata)
    end
  end

  // ------------------------------------------------------------------
  // Drivers with the reference model
  // ------------------------------------------------------------------
  task automatic chk_irq();
    #1;
    `CHK("irq_out", |(m_flags & m_mask), irq_out)
  endtask

  // Status word the rules predict for the given live levels
  function automatic logic [31:0] status_exp(input logic [4:0] lv);
    status_exp = {13'h0000, gen_mode ? lv[4] : lv[3],
                  gen_mode ? lv[2] : lv[1], lv[0], 8'h00, m_flags};
  endfunction

  // Flags raised by one event cycle; load tracking runs in both modes
  function automatic void model_ev(input logic [7:0] e,
                                   input logic [1:0] rd);
    logic [7:0] s;
    s = e & 8'hFD;
    // A read in the load cycle takes the old value, so no overrun
    s[1] = (e[5] & m_unrd_a & ~rd[0]) | (e[6] & m_unrd_b & ~rd[1]);
    m_unrd_a = e[5] | (m_unrd_a & ~rd[0]);
    m_unrd_b = e[6] | (m_unrd_b & ~rd[1]);
    if (gen_mode)
      s = s & ~tcs_pkg::CAPTURE_ONLY;
    else
      s = s & ~tcs_pkg::GENERATE_ONLY;
    m_flags = m_flags | s;
  endfunction

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    if (a == tcs_pkg::OFS_IRQ_SET)
      m_mask = m_mask | d[7:0];
    if (a == tcs_pkg::OFS_IRQ_CLEAR)
      m_mask = m_mask & ~d[7:0];
    chk_irq();
  endtask

  task automatic reg_read(input logic [7:0] a, input string nm);
    logic [31:0] ex;
    logic [4:0]  lv;
    lv = 5'($random(seed));
    ex = 32'h0000_0000;
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    live_r <= lv;
    if (a == tcs_pkg::OFS_STATUS)
      ex = status_exp(lv);
    if (a == tcs_pkg::OFS_MASK_VIEW)
      ex[7:0] = m_mask;
    exp_q.push_back(ex);
    nm_q.push_back(nm);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    if (a == tcs_pkg::OFS_STATUS)
      m_flags = 8'h00;
    chk_irq();
  endtask

  task automatic pulse(input logic [7:0] e, input logic [1:0] rd);
    @(posedge sys_clk);
    ev_r <= e;
    crd_r <= rd;
    @(posedge sys_clk);
    ev_r <= 8'h00;
    crd_r <= 2'b00;
    model_ev(e, rd);
    chk_irq();
  endtask

  // Event, then a status read one cycle later beside a second event
  task automatic ev_then_read(input logic [7:0] e1, input logic [7:0] e2);
    @(posedge sys_clk);
    ev_r <= e1;
    @(posedge sys_clk);
    model_ev(e1, 2'b00);
    exp_q.push_back(status_exp(live_r));
    nm_q.push_back("status");
    ev_r <= e2;
    reg_rd <= 1'b1;
    reg_addr <= tcs_pkg::OFS_STATUS;
    @(posedge sys_clk);
    ev_r <= 8'h00;
    reg_rd <= 1'b0;
    m_flags = 8'h00;
    model_ev(e2, 2'b00);
    chk_irq();
  endtask

  task automatic set_mode(input logic m);
    @(posedge sys_clk);
    gen_mode <= m;
    @(posedge sys_clk);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    int          i;
    int          md;
    logic [31:0] rv;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    reg_read(tcs_pkg::OFS_STATUS, "status");
    reg_read(tcs_pkg::OFS_MASK_VIEW, "mask_view");
    reg_read(tcs_pkg::OFS_IRQ_SET, "enable_set");
    reg_read(tcs_pkg::OFS_IRQ_CLEAR, "enable_clear");
    reg_read(8'h10, "unmapped");
    $display("test reset_values done");

    repeat (8)
    begin
      reg_write(tcs_pkg::OFS_IRQ_SET, 32'($random(seed)));
      reg_read(tcs_pkg::OFS_MASK_VIEW, "mask_view");
      reg_write(tcs_pkg::OFS_IRQ_CLEAR, 32'($random(seed)));
      reg_read(tcs_pkg::OFS_MASK_VIEW, "mask_view");
    end
    reg_write(tcs_pkg::OFS_STATUS, 32'h0000_00FF);
    reg_write(tcs_pkg::OFS_MASK_VIEW, 32'h0000_00FF);
    reg_read(tcs_pkg::OFS_MASK_VIEW, "mask_view");
    $display("test mask_set_clear done");

    reg_write(tcs_pkg::OFS_IRQ_SET, 32'h0000_00FF);
    for (md = 0; md < 2; md++)
    begin
      set_mode(md[0]);
      for (i = 0; i < 8; i++)
      begin
        pulse(8'h01 << i, 2'b00);
        pulse(8'h01 << i, 2'b00);
        reg_read(tcs_pkg::OFS_STATUS, "status");
      end
      pulse(8'h00, 2'b11);
      reg_read(tcs_pkg::OFS_STATUS, "status");
    end
    set_mode(1'b0);
    $display("test event_flags done");

    pulse(8'h20, 2'b00);
    pulse(8'h20, 2'b01);
    pulse(8'h40, 2'b00);
    pulse(8'h40, 2'b00);
    reg_read(tcs_pkg::OFS_STATUS, "status");
    pulse(8'h00, 2'b11);
    pulse(8'h60, 2'b00);
    pulse(8'h00, 2'b01);
    pulse(8'h60, 2'b00);
    reg_read(tcs_pkg::OFS_STATUS, "status");
    reg_read(tcs_pkg::OFS_STATUS, "status");
    $display("test load_overrun done");

    ev_then_read(8'h11, 8'h00);
    ev_then_read(8'h80, 8'h80);
    reg_read(tcs_pkg::OFS_STATUS, "status");
    $display("test set_beside_clear done");

    reg_write(tcs_pkg::OFS_IRQ_CLEAR, 32'h0000_00FF);
    pulse(8'hFD, 2'b11);
    reg_write(tcs_pkg::OFS_IRQ_SET, 32'h0000_0080);
    reg_read(tcs_pkg::OFS_STATUS, "status");
    $display("test irq_masking done");

    repeat (150)
    begin
      rv = 32'($random(seed));
      if (rv[3:0] == 4'h0)
      begin
        reg_read(tcs_pkg::OFS_STATUS, "status");
        set_mode(rv[4]);
      end
      pulse(rv[15:8], gen_mode ? 2'b00 : rv[17:16]);
      if (rv[19:18] == 2'b00)
        reg_write(rv[20] ? tcs_pkg::OFS_IRQ_SET : tcs_pkg::OFS_IRQ_CLEAR,
                  {24'h00_0000, rv[31:24]});
      if (rv[21])
        reg_read(tcs_pkg::OFS_STATUS, "status");
      if (rv[23:22] == 2'b00)
        reg_read(tcs_pkg::OFS_MASK_VIEW, "mask_view");
    end
    reg_read(tcs_pkg::OFS_STATUS, "status");
    $display("test random_traffic done");
    repeat (3) @(posedge sys_clk);
    end_of_test();
  end

endmodule
